/* design/rbmd_sram.sv */
// Internal SRAM: 32-bit wide, byte lanes, one-cycle access, registered read data
`timescale 1ns/100ps
module rbmd_sram
	import rbmd_pkg::*;
(
	input wire logic clk_in,
	rbmd_sram_if.slave mem
);
	logic [RBMD_DATA_W-1:0] store [RBMD_SRAM_WORDS];
	logic [RBMD_DATA_W-1:0] rdata_ff;

	// Little-endian only: lane 0 holds the lowest byte address
	always_ff @(posedge clk_in)
	begin
		if (mem.en && mem.wr)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (mem.byte_en[i])
				begin
					store[mem.word_addr][i*8 +: 8] <= mem.wdata[i*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (mem.en && !mem.wr)
		begin
			rdata_ff <= store[mem.word_addr];
		end
	end

	assign mem.rdata = rdata_ff;
endmodule

/* design/rbmd_top.sv */
// Reset, strap capture, debug-port select, address decode, remap and abort logic
//
// Functional notes
// - After external or watchdog reset every peripheral I/O line is an input.
// - External reset asserts asynchronously; its release is synchronised to the clock.
// - Reset restores register defaults and forces the next fetch to address zero.
// - Test-port reset clears only the controller picked by the captured select level.
// - Watchdog reset acts like external reset but keeps boot and float modes.
// - External reset wins over a simultaneous watchdog reset.
// - Float strap low for the last ten cycles enters float mode, outputs off; code only raises FLOAT_MODE_OUT.
// - Low select gives in-circuit emulation, high gives boundary scan, no ID code.
// - Debug mode changes only after both external and test-port reset.
// - Decode lowest 4 MB internal, highest 4 MB peripherals, middle external.
// - Every region uses little-endian byte order only.
// - 8 KB SRAM, 32 bits wide, single-cycle byte, half and word access.
// - After remap the SRAM appears at address zero for vector rewrites.
// - Boot-width strap in last ten cycles: 1 selects 8-bit, 0 selects 16-bit.
// - Writing one to the remap bit swaps in SRAM; only a reset undoes it.
// - Undefined external addresses abort; internal regions never abort.
// - External unit serves the middle space in up to eight 16 MB banks.
// - Each bank has wait, float, width, byte-write and early-read settings.
`timescale 1ns/100ps
module rbmd_top
	import rbmd_pkg::*;
#(
	parameter int NUM_BANKS = RBMD_NUM_BANKS
)
(
	// Clock and resets
	input wire logic CLK_IN,
	input wire logic EXT_RESET_N_IN,
	input wire logic WDOG_RESET_IN,
	input wire logic TAP_RESET_N_IN,
	// Straps and debug select pins
	input wire logic BOOT_WIDTH_STRAP_IN,
	input wire logic FLOAT_OUTPUTS_STRAP_N_IN,
	input wire logic DEBUG_PORT_SELECT_IN,
	// Core bus
	input wire logic BUS_VALID_IN,
	input wire logic BUS_WRITE_IN,
	input wire logic BUS_FETCH_IN,
	input wire logic [1:0] BUS_SIZE_IN,
	input wire logic [RBMD_ADDR_W-1:0] BUS_ADDR_IN,
	input wire logic [RBMD_DATA_W-1:0] BUS_WDATA_IN,
	output logic [RBMD_DATA_W-1:0] BUS_RDATA_OUT,
	output logic BUS_READY_OUT,
	output logic DATA_ABORT_OUT,
	output logic PREFETCH_ABORT_OUT,
	// Control bits
	input wire logic REMAP_COMMAND_BIT_IN,
	input wire logic [NUM_BANKS-1:0] BANK_ENABLE_IN,
	input wire rbmd_bank_cfg_s BANK_CFG_IN [NUM_BANKS],
	// Region selects
	output logic PERIPH_SEL_OUT,
	output logic EXT_SEL_OUT,
	output logic [NUM_BANKS-1:0] CHIP_SELECT_OUT,
	output rbmd_bank_cfg_s EXT_CFG_OUT,
	// Reset and mode outputs
	output logic SYS_RESET_N_OUT,
	output logic CORE_FETCH_ZERO_OUT,
	output logic PIO_INPUT_MODE_OUT,
	output logic FLOAT_MODE_OUT,
	output logic BOOT_8BIT_OUT,
	output logic REMAPPED_OUT,
	output logic DEBUG_SCAN_MODE_OUT,
	output logic ICE_TAP_RESET_N_OUT,
	output logic SCAN_TAP_RESET_N_OUT
);
	logic ext_sync1_ff;
	logic ext_sync2_ff;
	logic ext_seen_ff;
	logic wd_sync1_ff;
	logic wd_sync2_ff;
	logic tap_sync1_ff;
	logic tap_sync2_ff;
	logic boot_sync1_ff;
	logic boot_sync2_ff;
	logic float_sync1_ff;
	logic float_sync2_ff;
	logic dsel_sync1_ff;
	logic dsel_sync2_ff;
	logic sys_rst_n_ff;
	rbmd_rst_state_e rst_state_ff;
	logic [3:0] boot_hi_cnt_ff;
	logic [3:0] boot_lo_cnt_ff;
	logic [3:0] float_lo_cnt_ff;
	logic float_mode_ff;
	rbmd_boot_e boot_mode_ff;
	rbmd_dbg_e dbg_mode_ff;
	logic dbg_pending_ff;
	logic remap_ff;
	logic fetch_zero_ff;
	logic [RBMD_DATA_W-1:0] rdata_ff;
	logic ready_ff;
	logic dabort_ff;
	logic pabort_ff;
	logic periph_sel_ff;
	logic ext_sel_ff;
	logic [NUM_BANKS-1:0] cs_ff;
	rbmd_bank_cfg_s ext_cfg_ff;
	logic ice_tap_rst_n_ff;
	logic scan_tap_rst_n_ff;
	logic sram_rd_pending_ff;

	logic [9:0] region;
	logic in_int;
	logic in_periph;
	logic in_ext;
	logic sram_hit;
	logic boot_hit;
	logic [2:0] bank_idx;
	logic bank_defined;
	logic [3:0] lane_en;
	logic [RBMD_SRAM_AW-1:0] sram_word;

	rbmd_sram_if sram_bus ();

	rbmd_sram u_sram
	(
		.clk_in(CLK_IN),
		.mem(sram_bus.slave)
	);

	// Pins are asynchronous to the clock, so two stages before any use
	always_ff @(posedge CLK_IN or negedge EXT_RESET_N_IN)
	begin
		if (!EXT_RESET_N_IN)
		begin
			ext_sync1_ff <= 1'b0;
			ext_sync2_ff <= 1'b0;
			ext_seen_ff <= 1'b0;
		end
		else
		begin
			ext_sync1_ff <= 1'b1;
			ext_sync2_ff <= ext_sync1_ff;
			ext_seen_ff <= ext_sync2_ff;
		end
	end

	// Straps sampled free-running, even while reset is held
	always_ff @(posedge CLK_IN)
	begin
		wd_sync1_ff <= WDOG_RESET_IN;
		wd_sync2_ff <= wd_sync1_ff;
		tap_sync1_ff <= TAP_RESET_N_IN;
		tap_sync2_ff <= tap_sync1_ff;
		boot_sync1_ff <= BOOT_WIDTH_STRAP_IN;
		boot_sync2_ff <= boot_sync1_ff;
		float_sync1_ff <= FLOAT_OUTPUTS_STRAP_N_IN;
		float_sync2_ff <= float_sync1_ff;
		dsel_sync1_ff <= DEBUG_PORT_SELECT_IN;
		dsel_sync2_ff <= dsel_sync1_ff;
	end

	// Internal reset: external pin is async; watchdog pulls a synchronous reset
	always_ff @(posedge CLK_IN or negedge EXT_RESET_N_IN)
	begin
		if (!EXT_RESET_N_IN)
		begin
			rst_state_ff <= RBMD_RST_ACTIVE;
			sys_rst_n_ff <= 1'b0;
		end
		else
		begin
			case (rst_state_ff)
				RBMD_RST_ACTIVE:
				begin
					if (ext_sync2_ff && !wd_sync2_ff)
					begin
						rst_state_ff <= RBMD_RST_RUN;
						sys_rst_n_ff <= 1'b1;
					end
				end
				RBMD_RST_RUN:
				begin
					if (wd_sync2_ff)
					begin
						rst_state_ff <= RBMD_RST_ACTIVE;
						sys_rst_n_ff <= 1'b0;
					end
				end
				default:
				begin
					rst_state_ff <= RBMD_RST_ACTIVE;
					sys_rst_n_ff <= 1'b0;
				end
			endcase
		end
	end

	// Run-length of each boot-strap level and of float-strap low while the pin reset is held
	always_ff @(posedge CLK_IN)
	begin
		if (ext_sync2_ff)
		begin
			boot_hi_cnt_ff <= '0;
			boot_lo_cnt_ff <= '0;
			float_lo_cnt_ff <= '0;
		end
		else
		begin
			boot_hi_cnt_ff <= boot_sync2_ff ?
				((boot_hi_cnt_ff == RBMD_STRAP_CNT_MAX) ? boot_hi_cnt_ff : boot_hi_cnt_ff + 4'h1)
				: 4'h0;
			boot_lo_cnt_ff <= !boot_sync2_ff ?
				((boot_lo_cnt_ff == RBMD_STRAP_CNT_MAX) ? boot_lo_cnt_ff : boot_lo_cnt_ff + 4'h1)
				: 4'h0;
			float_lo_cnt_ff <= !float_sync2_ff ?
				((float_lo_cnt_ff == RBMD_STRAP_CNT_MAX) ? float_lo_cnt_ff : float_lo_cnt_ff + 4'h1)
				: 4'h0;
		end
	end

	// Latched on the pin-reset release edge only; watchdog resets leave them
	always_ff @(posedge CLK_IN)
	begin
		// Edge taken after the second stage; the first may still be settling
		if (ext_sync2_ff && !ext_seen_ff)
		begin
			float_mode_ff <= (float_lo_cnt_ff == RBMD_STRAP_CNT_MAX) && !float_sync2_ff;
			if ((boot_hi_cnt_ff == RBMD_STRAP_CNT_MAX) && boot_sync2_ff)
			begin
				boot_mode_ff <= RBMD_BOOT_8BIT;
			end
			else if ((boot_lo_cnt_ff == RBMD_STRAP_CNT_MAX) && !boot_sync2_ff)
			begin
				boot_mode_ff <= RBMD_BOOT_16BIT;
			end
			dbg_pending_ff <= dsel_sync2_ff;
		end
	end

	// Debug mode commits only once test-port reset is also seen after the pin reset
	always_ff @(posedge CLK_IN)
	begin
		if (!tap_sync2_ff)
		begin
			dbg_mode_ff <= dbg_pending_ff ? RBMD_DBG_SCAN : RBMD_DBG_ICE;
		end
	end

	// Test-port reset steered to the selected controller only
	always_ff @(posedge CLK_IN or negedge EXT_RESET_N_IN)
	begin
		if (!EXT_RESET_N_IN)
		begin
			ice_tap_rst_n_ff <= 1'b1;
			scan_tap_rst_n_ff <= 1'b1;
		end
		else
		begin
			ice_tap_rst_n_ff <= !(!tap_sync2_ff && (dbg_pending_ff == 1'b0));
			scan_tap_rst_n_ff <= !(!tap_sync2_ff && (dbg_pending_ff == 1'b1));
		end
	end

	// Remap is sticky; only an internal or pin reset clears it
	always_ff @(posedge CLK_IN or negedge EXT_RESET_N_IN)
	begin
		if (!EXT_RESET_N_IN)
		begin
			remap_ff <= 1'b0;
			fetch_zero_ff <= 1'b1;
		end
		else if (!sys_rst_n_ff)
		begin
			remap_ff <= 1'b0;
			fetch_zero_ff <= 1'b1;
		end
		else
		begin
			if (REMAP_COMMAND_BIT_IN)
			begin
				remap_ff <= 1'b1;
			end
			if (BUS_VALID_IN && BUS_FETCH_IN)
			begin
				fetch_zero_ff <= 1'b0;
			end
		end
	end

	// Region decode on the top ten address bits
	always_comb
	begin
		region = BUS_ADDR_IN[RBMD_ADDR_W-1:RBMD_REGION_LSB];
		in_int = (region == RBMD_REGION_INT);
		in_periph = (region == RBMD_REGION_PERIPH);
		in_ext = !in_int && !in_periph;
		// Before remap, low space belongs to boot memory on chip select zero
		sram_hit = in_int && remap_ff;
		boot_hit = in_int && !remap_ff;
		bank_idx = BUS_ADDR_IN[RBMD_BANK_LSB +: 3];
		bank_defined = BANK_ENABLE_IN[bank_idx] || (bank_idx == 3'h0);
		sram_word = BUS_ADDR_IN[2 +: RBMD_SRAM_AW];
		if (BUS_SIZE_IN == RBMD_SIZE_BYTE)
		begin
			lane_en = 4'h1 << BUS_ADDR_IN[1:0];
		end
		else if (BUS_SIZE_IN == RBMD_SIZE_HALF)
		begin
			lane_en = BUS_ADDR_IN[1] ? 4'hc : 4'h3;
		end
		else
		begin
			lane_en = 4'hf;
		end
	end

	assign sram_bus.en = BUS_VALID_IN && sram_hit && sys_rst_n_ff;
	assign sram_bus.wr = BUS_WRITE_IN;
	assign sram_bus.byte_en = lane_en;
	assign sram_bus.word_addr = sram_word;
	assign sram_bus.wdata = BUS_WDATA_IN;

	// Selects and aborts registered one cycle after the request
	always_ff @(posedge CLK_IN or negedge EXT_RESET_N_IN)
	begin
		if (!EXT_RESET_N_IN)
		begin
			ready_ff <= 1'b0;
			dabort_ff <= 1'b0;
			pabort_ff <= 1'b0;
			periph_sel_ff <= 1'b0;
			ext_sel_ff <= 1'b0;
			cs_ff <= '0;
			ext_cfg_ff <= '0;
			sram_rd_pending_ff <= 1'b0;
		end
		else
		begin
			ready_ff <= BUS_VALID_IN && sys_rst_n_ff && (sram_hit || in_periph);
			dabort_ff <= BUS_VALID_IN && sys_rst_n_ff && in_ext && !bank_defined
				&& !BUS_FETCH_IN;
			pabort_ff <= BUS_VALID_IN && sys_rst_n_ff && in_ext && !bank_defined
				&& BUS_FETCH_IN;
			periph_sel_ff <= BUS_VALID_IN && sys_rst_n_ff && in_periph;
			ext_sel_ff <= BUS_VALID_IN && sys_rst_n_ff && ((in_ext && bank_defined) || boot_hit);
			sram_rd_pending_ff <= sram_bus.en && !BUS_WRITE_IN;
			cs_ff <= '0;
			if (BUS_VALID_IN && sys_rst_n_ff && boot_hit)
			begin
				cs_ff[0] <= 1'b1;
				ext_cfg_ff <= BANK_CFG_IN[0];
				ext_cfg_ff.wide16 <= (boot_mode_ff == RBMD_BOOT_16BIT);
			end
			else if (BUS_VALID_IN && sys_rst_n_ff && in_ext && bank_defined)
			begin
				cs_ff[bank_idx] <= 1'b1;
				ext_cfg_ff <= BANK_CFG_IN[bank_idx];
			end
		end
	end

	assign rdata_ff = sram_rd_pending_ff ? sram_bus.rdata : '0;

	// Float mode only flagged on FLOAT_MODE_OUT, no output is gated; reset holds PIO lines as inputs
	always_ff @(posedge CLK_IN or negedge EXT_RESET_N_IN)
	begin
		if (!EXT_RESET_N_IN)
		begin
			BUS_RDATA_OUT <= '0;
			BUS_READY_OUT <= 1'b0;
			DATA_ABORT_OUT <= 1'b0;
			PREFETCH_ABORT_OUT <= 1'b0;
			PERIPH_SEL_OUT <= 1'b0;
			EXT_SEL_OUT <= 1'b0;
			CHIP_SELECT_OUT <= '0;
			EXT_CFG_OUT <= '0;
			SYS_RESET_N_OUT <= 1'b0;
			CORE_FETCH_ZERO_OUT <= 1'b1;
			PIO_INPUT_MODE_OUT <= 1'b1;
			FLOAT_MODE_OUT <= 1'b0;
			BOOT_8BIT_OUT <= 1'b0;
			REMAPPED_OUT <= 1'b0;
			DEBUG_SCAN_MODE_OUT <= 1'b0;
			ICE_TAP_RESET_N_OUT <= 1'b1;
			SCAN_TAP_RESET_N_OUT <= 1'b1;
		end
		else
		begin
			BUS_RDATA_OUT <= rdata_ff;
			BUS_READY_OUT <= ready_ff || sram_rd_pending_ff;
			DATA_ABORT_OUT <= dabort_ff;
			PREFETCH_ABORT_OUT <= pabort_ff;
			PERIPH_SEL_OUT <= periph_sel_ff;
			EXT_SEL_OUT <= ext_sel_ff;
			CHIP_SELECT_OUT <= cs_ff;
			EXT_CFG_OUT <= ext_cfg_ff;
			SYS_RESET_N_OUT <= sys_rst_n_ff;
			CORE_FETCH_ZERO_OUT <= fetch_zero_ff || !sys_rst_n_ff;
			PIO_INPUT_MODE_OUT <= !sys_rst_n_ff;
			FLOAT_MODE_OUT <= float_mode_ff;
			BOOT_8BIT_OUT <= (boot_mode_ff == RBMD_BOOT_8BIT);
			REMAPPED_OUT <= remap_ff;
			DEBUG_SCAN_MODE_OUT <= (dbg_mode_ff == RBMD_DBG_SCAN);
			ICE_TAP_RESET_N_OUT <= ice_tap_rst_n_ff;
			SCAN_TAP_RESET_N_OUT <= scan_tap_rst_n_ff;
		end
	end
endmodule

/* dv/rbmd_ext_mem_model.sv */
// External devices: fitted banks, their settings and a count of select strobes
`timescale 1ns/100ps
module rbmd_ext_mem_model
	import rbmd_pkg::*;
(
	// Clock, reset and population
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [RBMD_NUM_BANKS-1:0] fitted_in,
	// Block side
	input wire logic [RBMD_NUM_BANKS-1:0] chip_select_in,
	output logic [RBMD_NUM_BANKS-1:0] bank_enable_out,
	output rbmd_bank_cfg_s bank_cfg_out [RBMD_NUM_BANKS],
	output logic [7:0] hits_out [RBMD_NUM_BANKS]
);
	assign bank_enable_out = fitted_in;
	// Distinct settings per bank, so a wrong bank shows at once
	always_comb
	begin
		for (int i = 0; i < RBMD_NUM_BANKS; i++)
			bank_cfg_out[i] = '{4'(i), 3'(i), i[0], i[1], i[2]};
	end
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < RBMD_NUM_BANKS; i++)
			begin
				hits_out[i] <= 8'h00;
			end
		end
		else
		begin
			for (int i = 0; i < RBMD_NUM_BANKS; i++)
			begin
				hits_out[i] <= hits_out[i] + 8'(chip_select_in[i]);
			end
		end
	end
endmodule

/* dv/rbmd_top_monitor.sv */
// Checker for reset, strap, decode and remap relations at the top ports
`timescale 1ns/100ps
module rbmd_top_monitor
	import rbmd_pkg::*;
#(
	parameter int NUM_BANKS = RBMD_NUM_BANKS
)
(
	// Clock, reset and bus
	input wire logic CLK_IN,
	input wire logic EXT_RESET_N_IN,
	input wire logic BUS_VALID_IN,
	input wire logic BUS_WRITE_IN,
	input wire logic BUS_FETCH_IN,
	input wire logic [RBMD_ADDR_W-1:0] BUS_ADDR_IN,
	input wire logic REMAP_COMMAND_BIT_IN,
	input wire logic [NUM_BANKS-1:0] BANK_ENABLE_IN,
	// Answers and modes
	input wire logic BUS_READY_OUT,
	input wire logic DATA_ABORT_OUT,
	input wire logic PREFETCH_ABORT_OUT,
	input wire logic PERIPH_SEL_OUT,
	input wire logic EXT_SEL_OUT,
	input wire logic [NUM_BANKS-1:0] CHIP_SELECT_OUT,
	input wire logic SYS_RESET_N_OUT,
	input wire logic CORE_FETCH_ZERO_OUT,
	input wire logic PIO_INPUT_MODE_OUT,
	input wire logic FLOAT_MODE_OUT,
	input wire logic BOOT_8BIT_OUT,
	input wire logic REMAPPED_OUT,
	input wire logic ICE_TAP_RESET_N_OUT,
	input wire logic SCAN_TAP_RESET_N_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!EXT_RESET_N_IN);
	logic [3:0] since_rel_ff;
	logic taken;
	logic mid;
	assign taken = BUS_VALID_IN && SYS_RESET_N_OUT;
	// Banks 1 to 7 only, so the boot window of bank 0 stays out
	assign mid = taken && REMAPPED_OUT && BUS_ADDR_IN[31:27] == 5'h00 && BUS_ADDR_IN[26:24] != 3'h0;
	// Straps may only move shortly after an external release
	always_ff @(posedge CLK_IN or negedge EXT_RESET_N_IN)
	begin
		if (!EXT_RESET_N_IN)
			since_rel_ff <= 4'h0;
		else if (since_rel_ff != 4'hf)
			since_rel_ff <= since_rel_ff + 4'h1;
	end
	sequence s_held_low;
		!SYS_RESET_N_OUT [*2];
	endsequence
	a_release_sync: assert property ($rose(EXT_RESET_N_IN) |-> s_held_low ##[1:12] SYS_RESET_N_OUT)
		else $error("reset release not synchronised");
	a_reset_state: assert property (!SYS_RESET_N_OUT |-> PIO_INPUT_MODE_OUT && CORE_FETCH_ZERO_OUT)
		else $error("reset state wrong");
	a_tap_single: assert property (ICE_TAP_RESET_N_OUT || SCAN_TAP_RESET_N_OUT)
		else $error("both test controllers reset");
	a_straps_kept: assert property ($changed(BOOT_8BIT_OUT) || $changed(FLOAT_MODE_OUT) |-> since_rel_ff < 4'h8)
		else $error("strap mode moved outside release");
	a_periph_sel: assert property (taken && BUS_ADDR_IN[31:22] == RBMD_REGION_PERIPH |-> ##2 PERIPH_SEL_OUT && !DATA_ABORT_OUT && !PREFETCH_ABORT_OUT)
		else $error("peripheral decode wrong");
	a_int_no_abort: assert property (taken && BUS_ADDR_IN[31:22] == RBMD_REGION_INT |-> ##2 !DATA_ABORT_OUT && !PREFETCH_ABORT_OUT)
		else $error("internal access aborted");
	a_bank_select: assert property (mid && BANK_ENABLE_IN[BUS_ADDR_IN[26:24]] |-> ##2 EXT_SEL_OUT && CHIP_SELECT_OUT == NUM_BANKS'(1'h1) << $past(BUS_ADDR_IN[26:24], 2))
		else $error("bank select wrong");
	a_undef_abort: assert property (mid && !BANK_ENABLE_IN[BUS_ADDR_IN[26:24]] |-> ##2 !EXT_SEL_OUT && DATA_ABORT_OUT != PREFETCH_ABORT_OUT && PREFETCH_ABORT_OUT == $past(BUS_FETCH_IN, 2))
		else $error("undefined bank abort wrong");
	a_sram_read: assert property (taken && REMAPPED_OUT && !BUS_WRITE_IN && BUS_ADDR_IN < 32'h0000_2000 |-> ##2 BUS_READY_OUT)
		else $error("sram read late");
	a_remap_set: assert property ($rose(REMAP_COMMAND_BIT_IN) && SYS_RESET_N_OUT |-> ##[1:3] REMAPPED_OUT)
		else $error("remap not set");
	a_remap_undo: assert property ($fell(REMAPPED_OUT) |-> ##[0:2] !SYS_RESET_N_OUT)
		else $error("remap lost without reset");
endmodule
bind rbmd_top rbmd_top_monitor #(.NUM_BANKS(NUM_BANKS)) rbmd_top_monitor_inst (.CLK_IN, .EXT_RESET_N_IN,
	.BUS_VALID_IN, .BUS_WRITE_IN, .BUS_FETCH_IN, .BUS_ADDR_IN, .REMAP_COMMAND_BIT_IN,
	.BANK_ENABLE_IN, .BUS_READY_OUT, .DATA_ABORT_OUT, .PREFETCH_ABORT_OUT, .PERIPH_SEL_OUT,
	.EXT_SEL_OUT, .CHIP_SELECT_OUT, .SYS_RESET_N_OUT, .CORE_FETCH_ZERO_OUT, .PIO_INPUT_MODE_OUT,
	.FLOAT_MODE_OUT, .BOOT_8BIT_OUT, .REMAPPED_OUT, .ICE_TAP_RESET_N_OUT, .SCAN_TAP_RESET_N_OUT);

/* dv/tb.sv */
// Testbench: reset, straps, debug select, decode, SRAM, remap and abort
`timescale 1ns/100ps
module tb
	import rbmd_pkg::*;
;
	logic clk = 1'h0, rst_n = 1'h0, wdog = 1'h0, tap_n = 1'h1, boot = 1'h1, flt_n = 1'h1;
	logic dsel = 1'h1, valid = 1'h0, wr = 1'h0, fetch = 1'h0, remap = 1'h0;
	logic [1:0] size = 2'h2;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, s_rd;
	logic [7:0] fitted = 8'h07, bank_en, cs, s_cs;
	logic [7:0] hits [8];
	logic ready, dab, pab, psel, esel, sys_n, fz, pio, fm, b8, rmp, scan, ice_n, scan_n;
	logic s_rdy, s_per, s_ext, s_dab, s_pab;
	rbmd_bank_cfg_s cfg [8];
	rbmd_bank_cfg_s ext_cfg, s_cfg;
	int failures = 0, checks_done = 0;
	rbmd_top rbmd_top_inst (.CLK_IN(clk), .EXT_RESET_N_IN(rst_n), .WDOG_RESET_IN(wdog),
		.TAP_RESET_N_IN(tap_n), .BOOT_WIDTH_STRAP_IN(boot), .FLOAT_OUTPUTS_STRAP_N_IN(flt_n),
		.DEBUG_PORT_SELECT_IN(dsel), .BUS_VALID_IN(valid), .BUS_WRITE_IN(wr), .BUS_FETCH_IN(fetch),
		.BUS_SIZE_IN(size), .BUS_ADDR_IN(addr), .BUS_WDATA_IN(wdata), .BUS_RDATA_OUT(rdata),
		.BUS_READY_OUT(ready), .DATA_ABORT_OUT(dab), .PREFETCH_ABORT_OUT(pab),
		.REMAP_COMMAND_BIT_IN(remap), .BANK_ENABLE_IN(bank_en), .BANK_CFG_IN(cfg),
		.PERIPH_SEL_OUT(psel), .EXT_SEL_OUT(esel), .CHIP_SELECT_OUT(cs), .EXT_CFG_OUT(ext_cfg),
		.SYS_RESET_N_OUT(sys_n), .CORE_FETCH_ZERO_OUT(fz), .PIO_INPUT_MODE_OUT(pio),
		.FLOAT_MODE_OUT(fm), .BOOT_8BIT_OUT(b8), .REMAPPED_OUT(rmp), .DEBUG_SCAN_MODE_OUT(scan),
		.ICE_TAP_RESET_N_OUT(ice_n), .SCAN_TAP_RESET_N_OUT(scan_n));
	rbmd_ext_mem_model rbmd_ext_mem_model_inst (.clk_in(clk), .rst_n_in(rst_n),
		.fitted_in(fitted), .chip_select_in(cs), .bank_enable_out(bank_en),
		.bank_cfg_out(cfg), .hits_out(hits));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("checks=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wait_for(input logic lvl);
		int n;
		n = 0;
		while (sys_n !== lvl && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		chk(sys_n, lvl);
	endtask
	task rst(input logic b, input logic f, input logic d, input logic w);
		@(negedge clk);
		rst_n = 1'h0;
		{boot, flt_n, dsel, wdog} = {b, f, d, w};
		repeat (12) @(negedge clk);
		chk({pio, fz, sys_n}, 3'h6);
		rst_n = 1'h1;
		wdog = 1'h0;
		wait_for(1'h1);
	endtask
	task tap_pulse(input logic exp_scan);
		@(negedge clk);
		tap_n = 1'h0;
		repeat (5) @(negedge clk);
		chk(scan, exp_scan);
		chk({ice_n, scan_n}, exp_scan ? 2'h2 : 2'h1);
		tap_n = 1'h1;
		repeat (4) @(negedge clk);
	endtask
	// Answers land within three edges, so four sampled edges cover any kind
	task acc(input logic [31:0] a, input logic w, input logic f, input logic [1:0] sz,
		input logic [31:0] d);
		@(negedge clk);
		{valid, addr, wr, fetch, size, wdata} = {1'h1, a, w, f, sz, d};
		@(negedge clk);
		valid = 1'h0;
		{s_rdy, s_per, s_ext, s_dab, s_pab, s_cs, s_cfg} = '0;
		repeat (4)
		begin
			@(posedge clk);
			#1;
			{s_rdy, s_per, s_ext} = {s_rdy | ready, s_per | psel, s_ext | esel};
			{s_dab, s_pab, s_cs} = {s_dab | dab, s_pab | pab, s_cs | cs};
			if (ready === 1'h1)
				s_rd = rdata;
			if (esel === 1'h1)
				s_cfg = ext_cfg;
		end
	endtask
	task t_power_up;
		rst(1'h1, 1'h1, 1'h1, 1'h0);
		chk({b8, fm}, 2'h2);
		tap_pulse(1'h1);
		dsel = 1'h0;
		tap_pulse(1'h1);
		$display("test power_up done");
	endtask
	task t_boot_decode;
		chk(fz, 1'h1);
		acc(32'h0, 1'h0, 1'h1, 2'h2, 32'h0);
		chk({s_ext, s_cs, s_dab, s_pab, s_cfg.wide16, fz}, 13'h1010);
		acc(32'hffff_f004, 1'h0, 1'h0, 2'h2, 32'h0);
		chk({s_per, s_dab, s_pab}, 3'h4);
		acc(32'h003f_fffc, 1'h0, 1'h0, 2'h2, 32'h0);
		chk({s_dab, s_pab}, 2'h0);
		$display("test boot_decode done");
	endtask
	task t_remap_sram;
		@(negedge clk);
		remap = 1'h1;
		@(negedge clk);
		remap = 1'h0;
		repeat (3) @(negedge clk);
		chk(rmp, 1'h1);
		acc(32'h0, 1'h1, 1'h0, 2'h2, 32'h4433_2211);
		acc(32'h2, 1'h1, 1'h0, 2'h0, 32'haaaa_aaaa);
		acc(32'h1c, 1'h1, 1'h0, 2'h2, 32'h0);
		acc(32'h1e, 1'h1, 1'h0, 2'h1, 32'hbeef_beef);
		chk(s_rdy, 1'h1);
		acc(32'h0, 1'h0, 1'h0, 2'h2, 32'h0);
		chk(s_rd, 32'h44aa_2211);
		acc(32'h1c, 1'h0, 1'h1, 2'h2, 32'h0);
		chk(s_rdy, 1'h1);
		chk(s_rd, 32'hbeef_0000);
		$display("test remap_sram done");
	endtask
	// Runs only after the remap, as the monitor's bank checks demand
	task t_ext_banks;
		acc(32'h0200_0010, 1'h0, 1'h0, 2'h2, 32'h0);
		chk({s_ext, s_cs, s_dab, s_pab}, 11'h410);
		chk(s_cfg, 10'h092);
		acc(32'h0300_0000, 1'h1, 1'h0, 2'h2, 32'h0);
		chk({s_dab, s_pab, s_ext}, 3'h4);
		acc(32'h0300_0000, 1'h0, 1'h1, 2'h2, 32'h0);
		chk({s_dab, s_pab, s_ext}, 3'h2);
		@(negedge clk);
		fitted = 8'hff;
		acc(32'h07ff_fffc, 1'h0, 1'h0, 2'h0, 32'h0);
		chk({s_cs, s_dab, hits[2], hits[7]}, {8'h80, 1'h0, 8'h01, 8'h01});
		$display("test ext_banks done");
	endtask
	task t_wdog;
		@(negedge clk);
		{boot, flt_n, wdog} = 3'h1;
		repeat (3) @(negedge clk);
		wdog = 1'h0;
		wait_for(1'h0);
		chk(pio, 1'h1);
		wait_for(1'h1);
		chk({b8, fm, rmp}, 3'h4);
		$display("test wdog done");
	endtask
	task t_ext_prio;
		rst(1'h0, 1'h0, 1'h0, 1'h1);
		repeat (20) @(negedge clk);
		chk({b8, fm, scan}, 3'h3);
		tap_pulse(1'h0);
		// Bank 0 settings say 8-bit, so only the strap can make it 16-bit
		acc(32'h0, 1'h0, 1'h0, 2'h2, 32'h0);
		chk({s_cs, s_cfg.wide16}, 9'h003);
		$display("test ext_prio done");
	endtask
	initial
	begin
		t_power_up();
		t_boot_decode();
		t_remap_sram();
		t_ext_banks();
		t_wdog();
		t_ext_prio();
		end_sim();
	end
	initial
	begin
		repeat (6000) @(posedge clk);
		failures++;
		$display("watchdog expired");
		end_sim();
	end
endmodule

/* shared/rbmd_pkg.sv */
// Package: shared constants and types for the reset, boot and memory decode block
package rbmd_pkg;
	localparam int RBMD_ADDR_W = 32;
	localparam int RBMD_DATA_W = 32;
	localparam int RBMD_STRAP_CYCLES = 10;
	localparam logic [3:0] RBMD_STRAP_CNT_MAX = 4'h9;
	localparam logic [9:0] RBMD_REGION_INT = 10'h000;
	localparam logic [9:0] RBMD_REGION_PERIPH = 10'h3ff;
	localparam int RBMD_REGION_LSB = 22;
	localparam int RBMD_BANK_LSB = 24;
	localparam int RBMD_NUM_BANKS = 8;
	localparam int RBMD_SRAM_BYTES = 8192;
	localparam int RBMD_SRAM_WORDS = RBMD_SRAM_BYTES / 4;
	localparam int RBMD_SRAM_AW = $clog2(RBMD_SRAM_WORDS);
	localparam logic [RBMD_ADDR_W-1:0] RBMD_RESET_FETCH = 32'h0000_0000;
	localparam logic [1:0] RBMD_SIZE_BYTE = 2'h0;
	localparam logic [1:0] RBMD_SIZE_HALF = 2'h1;
	localparam logic [1:0] RBMD_SIZE_WORD = 2'h2;
	typedef enum logic {RBMD_BOOT_16BIT, RBMD_BOOT_8BIT} rbmd_boot_e;
	typedef enum logic {RBMD_DBG_ICE, RBMD_DBG_SCAN} rbmd_dbg_e;
	typedef enum {RBMD_RST_ACTIVE, RBMD_RST_RUN} rbmd_rst_state_e;
	typedef struct packed
	{
		logic [3:0] wait_states;
		logic [2:0] float_time;
		logic wide16;
		logic byte_write;
		logic early_read;
	} rbmd_bank_cfg_s;
endpackage

/* shared/rbmd_sram_if.sv */
// Interface: port between the decode logic and the internal SRAM
`timescale 1ns/100ps
interface rbmd_sram_if;
	import rbmd_pkg::*;
	logic en;
	logic wr;
	logic [3:0] byte_en;
	logic [RBMD_SRAM_AW-1:0] word_addr;
	logic [RBMD_DATA_W-1:0] wdata;
	logic [RBMD_DATA_W-1:0] rdata;
	modport master (output en, output wr, output byte_en, output word_addr, output wdata,
		input rdata);
	modport slave (input en, input wr, input byte_en, input word_addr, input wdata,
		output rdata);
endinterface
